// *** rtl/eecwp_core.sv ***
// Purpose: Configuration pair and write-protect decode of a two-wire EEPROM
// Assumes: Host drives the link clock; array storage sits outside
// Notes: Config commit happens on the stop that ends a clean write
//
// Functional notes
// - Protect enabled: array writes blocked in the range picked by select.
// - Protect disabled: select ignored, every location writable.
// - Select 00: upper quarter of the array protected.
// - Select 01: upper half of the array protected.
// - Select 10: upper three quarters of the array protected.
// - Select 11: whole array protected.
// - Second config byte: bit 6 write enable, bit 5 check, bits 2:0 address.
// - Address byte write enable clear means whole config write ignored.
// - Address byte read returns 0 in the write enable position.
// - Check bit must equal address bit 0, else write ignored.
// - Address byte read returns 0 in the check position.
// - Stored address sets device address byte bits 3 to 1.
// - Address byte bits 7, 4 and 3 read as 0.
// - Word address MSB set makes the write a config access.
// - Bad protection byte: abort, no data ack, no write cycle.
// - Address byte after protection byte is optional.
// - Bad address byte: abort, no data ack, no write.
// - More than two data bytes: abort, both registers unchanged.
// - After an address change only the new address is acknowledged.
// - Device answers only type 1010 with matching stored address.
// - Protection byte needs its write enable set, else ignored.
// - Lock check bit must equal lock bit, else ignored.
// - Once locked, every later config change is refused.
`timescale 1ns/10ps

`include "eecwp_regs.svh"

module eecwp_core
    import eecwp_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter logic [2:0] CLIENT_ADDR_RST = `EECWP_ACFG_RST
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Two-wire link, clock driven by the host
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Array write port toward the storage
    output logic arr_we,
    output logic [ADDR_W-1:0] arr_addr,
    output logic [7:0] arr_data,
    // Configuration read view
    output logic [7:0] prot_cfg_rd,
    output logic [7:0] addr_cfg_rd
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic link_bit_q;
    logic link_tog_q;
    logic tog_s1_q, tog_s2_q, tog_s3_q;
    logic scl_s1_q, scl_s2_q, scl_s3_q;
    logic sda_s1_q, sda_s2_q, sda_s3_q;
    logic bit_evt, start_det, stop_det, scl_fall;
    logic [3:0] bcnt_q;
    logic [6:0] shreg_q;
    logic byte_done;
    logic [7:0] byte_w;
    eecwp_state_t state_q;
    logic cfg_q;
    logic [1:0] dcnt_q;
    logic [15:0] waddr_q;
    logic ack_pend_q;
    logic sda_oe_q;
    logic prot_en_q;
    logic [1:0] prot_sel_q;
    logic lock_q;
    logic [2:0] client_q;
    logic new_pcfg_vld_q, new_acfg_vld_q;
    logic new_pen_q, new_lock_q;
    logic [1:0] new_psel_q;
    logic [2:0] new_client_q;
    logic arr_we_q;
    logic [ADDR_W-1:0] arr_addr_q;
    logic [7:0] arr_data_q;
    logic dev_match, pcfg_ok, acfg_ok, do_ack, do_abort;
    logic arr_hit_prot;

    // Named copy of the reset byte so its fields can be picked apart
    localparam logic [7:0] PCFG_RST = `EECWP_PCFG_RST;

    ////////////////////////////////////////////////////////////////////////
    // Link clock domain: one bit per rising edge of the host clock
    // Bit and toggle change together; the system side reads the bit only
    // after the synchronised toggle moves, so it is already stable.
    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            link_bit_q <= 1'b0;
            link_tog_q <= 1'b0;
        end else begin
            link_bit_q <= sda_i;
            link_tog_q <= ~link_tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers into the system clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= link_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    // Pins idle high on the bus, so reset to 1 avoids a false start
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end else begin
            scl_s1_q <= scl;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    // Bit event, clock fall, and frame edges: data moving while the clock stays high
    assign bit_evt = tog_s2_q ^ tog_s3_q;
    assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
    assign stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
    assign scl_fall = scl_s3_q & ~scl_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and shifter; count 8 is the acknowledge clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bcnt_q <= 4'h0;
            shreg_q <= 7'h00;
        end else if (start_det || stop_det) begin
            bcnt_q <= 4'h0;
        end else if (bit_evt) begin
            if (bcnt_q == `EECWP_ACK_SLOT) begin
                bcnt_q <= 4'h0;
            end else begin
                bcnt_q <= bcnt_q + 4'h1;
                shreg_q <= {shreg_q[5:0], link_bit_q};
            end
        end
    end

    assign byte_done = bit_evt && (bcnt_q == `EECWP_LAST_BIT);
    assign byte_w = {shreg_q, link_bit_q};

    ////////////////////////////////////////////////////////////////////////
    // Byte checks
    // Type code plus stored address; reads are not served by this block
    assign dev_match = (byte_w[7:4] == `EECWP_DEV_TYPE) &&
        (byte_w[3:1] == client_q) &&
        !byte_w[`EECWP_DEV_RW_POS];

    assign pcfg_ok = byte_w[`EECWP_PCFG_WEN_POS] &&
        (byte_w[`EECWP_PCFG_LCHK_POS] ==
         byte_w[`EECWP_PCFG_LOCK_POS]) &&
        !lock_q;

    assign acfg_ok = byte_w[`EECWP_ACFG_WEN_POS] &&
        (byte_w[`EECWP_ACFG_CHK_POS] ==
         byte_w[`EECWP_ACFG_ADDR_LO]);

    // Upper part of the array picked by the two top address bits
    always_comb begin
        arr_hit_prot = 1'b0;
        if (prot_en_q) begin
            case (prot_sel_q)
                2'b00: arr_hit_prot =
                    (waddr_q[ADDR_W-1 -: 2] == 2'b11);
                2'b01: arr_hit_prot = waddr_q[ADDR_W-1];
                2'b10: arr_hit_prot =
                    (waddr_q[ADDR_W-1 -: 2] != 2'b00);
                default: arr_hit_prot = 1'b1;
            endcase
        end
    end

    // Acknowledge or abort decision for the byte just completed
    always_comb begin
        do_ack = 1'b0;
        do_abort = 1'b0;
        case (state_q)
            EECWP_DEV: do_ack = dev_match;
            EECWP_AHI: do_ack = 1'b1;
            EECWP_ALO: do_ack = 1'b1;
            EECWP_DATA: begin
                if (!cfg_q) begin
                    do_ack = 1'b1;
                end else if (dcnt_q == 2'd0) begin
                    do_ack = pcfg_ok;
                    do_abort = !pcfg_ok;
                end else if (dcnt_q == 2'd1) begin
                    do_ack = acfg_ok;
                    do_abort = !acfg_ok;
                end else begin
                    do_abort = 1'b1;
                end
            end
            default: do_ack = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_q <= EECWP_IDLE;
            cfg_q <= 1'b0;
            dcnt_q <= 2'd0;
        end else if (start_det) begin
            state_q <= EECWP_DEV;
            dcnt_q <= 2'd0;
        end else if (stop_det) begin
            state_q <= EECWP_IDLE;
        end else if (byte_done) begin
            case (state_q)
                EECWP_DEV: state_q <= dev_match ? EECWP_AHI : EECWP_SKIP;
                EECWP_AHI: begin
                    cfg_q <= byte_w[`EECWP_CFG_SEL_POS];
                    state_q <= EECWP_ALO;
                end
                EECWP_ALO: state_q <= EECWP_DATA;
                EECWP_DATA: begin
                    if (do_abort) begin
                        state_q <= EECWP_SKIP;
                    end else if (dcnt_q != 2'd3) begin
                        dcnt_q <= dcnt_q + 2'd1;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // Word address; a page write wraps inside its page
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            waddr_q <= 16'h0000;
        end else if (byte_done && state_q == EECWP_AHI) begin
            waddr_q[15:8] <= byte_w;
        end else if (byte_done && state_q == EECWP_ALO) begin
            waddr_q[7:0] <= byte_w;
        end else if (arr_we_q) begin
            waddr_q[`EECWP_PAGE_BITS-1:0] <=
                waddr_q[`EECWP_PAGE_BITS-1:0] + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge drive: pull low from the fall after bit 8 to the next
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (start_det || stop_det) begin
            ack_pend_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (byte_done) begin
            ack_pend_q <= do_ack;
        end else if (scl_fall) begin
            sda_oe_q <= ack_pend_q;
            ack_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Staged configuration bytes; nothing reaches the live set before stop
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            new_pcfg_vld_q <= 1'b0;
            new_acfg_vld_q <= 1'b0;
            new_pen_q <= 1'b0;
            new_psel_q <= 2'b00;
            new_lock_q <= 1'b0;
            new_client_q <= 3'h0;
        end else if (start_det) begin
            new_pcfg_vld_q <= 1'b0;
            new_acfg_vld_q <= 1'b0;
        end else if (byte_done && state_q == EECWP_DATA && cfg_q) begin
            if (do_abort) begin
                new_pcfg_vld_q <= 1'b0;
                new_acfg_vld_q <= 1'b0;
            end else if (dcnt_q == 2'd0) begin
                new_pcfg_vld_q <= 1'b1;
                new_pen_q <= byte_w[`EECWP_PCFG_PEN_POS];
                new_psel_q <= {byte_w[`EECWP_PCFG_PSELH_POS],
                               byte_w[`EECWP_PCFG_PSELL_POS]};
                new_lock_q <= byte_w[`EECWP_PCFG_LOCK_POS];
            end else begin
                new_acfg_vld_q <= 1'b1;
                new_client_q <=
                    byte_w[`EECWP_ACFG_ADDR_HI:`EECWP_ACFG_ADDR_LO];
            end
        end
    end

    // Commit on stop; address byte optional, missing one keeps old value
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prot_en_q <= PCFG_RST[`EECWP_PCFG_PEN_POS];
            prot_sel_q <= PCFG_RST[`EECWP_PCFG_PSELH_POS:
                                   `EECWP_PCFG_PSELL_POS];
            lock_q <= PCFG_RST[`EECWP_PCFG_LOCK_POS];
            client_q <= CLIENT_ADDR_RST;
        end else if (stop_det && state_q == EECWP_DATA && cfg_q &&
                     new_pcfg_vld_q && !lock_q) begin
            prot_en_q <= new_pen_q;
            prot_sel_q <= new_psel_q;
            lock_q <= new_lock_q;
            if (new_acfg_vld_q) begin
                client_q <= new_client_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Array write port: protected targets never raise the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            arr_we_q <= 1'b0;
            arr_addr_q <= '0;
            arr_data_q <= 8'h00;
        end else begin
            arr_we_q <= byte_done && state_q == EECWP_DATA && !cfg_q &&
                        !arr_hit_prot;
            arr_addr_q <= waddr_q[ADDR_W-1:0];
            arr_data_q <= byte_w;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read view; enable, check and unused positions always read 0
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            prot_cfg_rd <= `EECWP_PCFG_RST;
            addr_cfg_rd <= 8'h00;
        end else begin
            prot_cfg_rd <= {4'h0, prot_en_q, prot_sel_q, lock_q};
            addr_cfg_rd <= {5'h00, client_q};
        end
    end

    // Open-drain data: only ever pulls low
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    assign sda_oe = sda_oe_q;
    assign arr_we = arr_we_q;
    assign arr_addr = arr_addr_q;
    assign arr_data = arr_data_q;

endmodule : eecwp_core

// *** rtl/eecwp_pkg.sv ***
// Purpose: Types shared by the configuration and write-protect logic
// Assumes: Constants live in eecwp_regs.svh
// Notes: Binary state codes written out
package eecwp_pkg;

    // Transfer sequencing on the two-wire link
    typedef enum logic [2:0] {
        EECWP_IDLE = 3'b000,
        EECWP_DEV = 3'b001,
        EECWP_AHI = 3'b010,
        EECWP_ALO = 3'b011,
        EECWP_DATA = 3'b100,
        EECWP_SKIP = 3'b101
    } eecwp_state_t;

endpackage : eecwp_pkg

// *** rtl/eecwp_regs.svh ***
// Purpose: Field positions, codes and reset values of the configuration pair
// Assumes: Included by eecwp_pkg users only; definitions only
// Notes: Byte 0 is the protection byte, byte 1 the client address byte
`ifndef EECWP_REGS_SVH
`define EECWP_REGS_SVH

// Device address byte
`define EECWP_DEV_TYPE 4'hA
`define EECWP_DEV_RW_POS 0

// Word address high byte: bit that selects configuration access
`define EECWP_CFG_SEL_POS 7

// Protection byte fields
`define EECWP_PCFG_WEN_POS 6
`define EECWP_PCFG_LCHK_POS 5
`define EECWP_PCFG_PEN_POS 3
`define EECWP_PCFG_PSELH_POS 2
`define EECWP_PCFG_PSELL_POS 1
`define EECWP_PCFG_LOCK_POS 0
`define EECWP_PCFG_RST 8'h00

// Client address byte fields
`define EECWP_ACFG_WEN_POS 6
`define EECWP_ACFG_CHK_POS 5
`define EECWP_ACFG_ADDR_HI 2
`define EECWP_ACFG_ADDR_LO 0
`define EECWP_ACFG_RST 3'h0

// Array page: low address bits that wrap during a page write
`define EECWP_PAGE_BITS 5

// Ninth clock of a byte is the acknowledge slot
`define EECWP_ACK_SLOT 4'h8
`define EECWP_LAST_BIT 4'h7

`endif

// *** testbench/eecwp_checker_assertions.sv ***
// Purpose: Port-level checks of the config and write-protect block
// Assumes: Read views mirror the stored configuration bytes
// Notes: Protected bound is rebuilt from the view, not from the body
`timescale 1ns/10ps

module eecwp_checker
    import eecwp_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Two-wire link
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Array port and read views
    input wire logic arr_we,
    input wire logic [ADDR_W-1:0] arr_addr,
    input wire logic [7:0] arr_data,
    input wire logic [7:0] prot_cfg_rd,
    input wire logic [7:0] addr_cfg_rd
);
    logic [ADDR_W-1:0] bound;

    // Lowest protected address, one quarter lower per select step
    assign bound = ADDR_W'(2'd3 - prot_cfg_rd[2:1]) << (ADDR_W - 2);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////
    // Open drain: the device may only pull low
    open_drain_a: assert property (sda_oe |-> !sda_o)
        else $error("sda driven high");
    prot_view_a: assert property (prot_cfg_rd[7:4] == 4'h0)
        else $error("protection view upper bits set");
    addr_view_a: assert property (addr_cfg_rd[7:3] == 5'h00)
        else $error("address view upper bits set");
    protect_a: assert property (arr_we && prot_cfg_rd[3] |-> arr_addr < bound)
        else $error("write into protected range");
    // Commit only lands while the bus is idle after a stop
    commit_idle_a: assert property ($changed(prot_cfg_rd) || $changed(addr_cfg_rd) |-> scl && sda_i)
        else $error("config changed mid transfer");
    lock_hold_a: assert property (prot_cfg_rd[0] |=> $stable(prot_cfg_rd) && $stable(addr_cfg_rd))
        else $error("locked config changed");
    ack_rise_a: assert property ($rose(sda_oe) |-> !scl)
        else $error("ack raised with clock high");
    ack_fall_a: assert property ($fell(sda_oe) |-> !scl)
        else $error("ack dropped with clock high");
    ack_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
        else $error("ack too short");

    cover property (arr_we && prot_cfg_rd[3]);
    cover property ($rose(sda_oe));
    cover property ($changed(addr_cfg_rd));
    cover property ($rose(prot_cfg_rd[0]));
endmodule : eecwp_checker

// *** testbench/eecwp_host_model.sv ***
// Purpose: Two-wire bus host that writes bytes and reads the ack
// Assumes: Steps on a 12 ns link base clock; line has a pull-up
// Notes: Each clock phase spans several base ticks so the sync keeps up
`timescale 1ns/10ps

module eecwp_host_model (
    // Base clock and wire level
    input wire logic lclk,
    input wire logic sda_line,
    // Bus drive
    output logic scl,
    output logic sda_pull
);
    // Idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task tick(input int n);
        repeat (n) @(posedge lclk);
    endtask : tick

    // Data falls while the clock is high
    task start();
        tick(1);
        sda_pull <= 1'b1;
        tick(3);
        scl <= 1'b0;
        tick(3);
    endtask : start

    // Data rises while the clock is high, then the clock stands still
    task stop();
        sda_pull <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_pull <= 1'b0;
        tick(6);
    endtask : stop

    // Data changes only while the clock is low
    task wbit(input logic b, output logic r);
        sda_pull <= !b;
        tick(3);
        scl <= 1'b1;
        tick(3);
        r = sda_line;
        tick(3);
        scl <= 1'b0;
        tick(3);
    endtask : wbit

    // MSB first, ninth slot released for the ack
    task wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) wbit(b[i], r);
        wbit(1'b1, r);
        ack = !r;
    endtask : wbyte
endmodule : eecwp_host_model

// *** testbench/tb.sv ***
// Purpose: Self-checking bench of config writes and write protection
// Assumes: ADDR_W 14, so the array ends at 3FFF
// Notes: Tasks run in order; later ones rely on the stored address
`timescale 1ns/10ps

module tb;
    localparam int LIMIT = 60000;
    localparam logic [7:0] DEV0 = 8'hA0;
    localparam logic [7:0] DEV5 = 8'hAA;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic resetn;
    logic scl, sda_pull, sda_line, sda_o, sda_oe, arr_we;
    logic [13:0] arr_addr, last_addr;
    logic [7:0] arr_data, prot_cfg_rd, addr_cfg_rd, last_data;
    logic [7:0] dev = DEV0;
    logic [5:0] ak;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_we = 0;

    // Clocks unrelated in phase
    initial forever #4 mclk = ~mclk;
    initial begin
        #3.3;
        forever #6 lclk = ~lclk;
    end

    // Open-drain wire with pull-up
    assign sda_line = !(sda_pull || (sda_oe && !sda_o));

    eecwp_core u_eecwp_core (.mclk, .resetn, .scl, .sda_i(sda_line),
        .sda_o, .sda_oe, .arr_we, .arr_addr, .arr_data, .prot_cfg_rd,
        .addr_cfg_rd);
    eecwp_host_model u_eecwp_host_model (.lclk, .sda_line, .scl, .sda_pull);

    ////////////////////////////////////////////////////////////////////////
    // Array write monitor and hang guard
    always @(posedge mclk) begin
        if (arr_we === 1'b1) begin
            n_we++;
            last_addr = arr_addr;
            last_data = arr_data;
        end
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            conclude();
        end
    end

    task check(input string nm, input logic [15:0] seen,
               input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Whole write transfer; ak holds one ack bit per byte
    task xfer(input logic [7:0] dv, input logic [15:0] wa,
              input logic [7:0] d [3], input int n);
        ak = 6'h00;
        u_eecwp_host_model.start();
        u_eecwp_host_model.wbyte(dv, ak[0]);
        if (ak[0]) begin
            u_eecwp_host_model.wbyte(wa[15:8], ak[1]);
            u_eecwp_host_model.wbyte(wa[7:0], ak[2]);
            for (int i = 0; i < n; i++) u_eecwp_host_model.wbyte(d[i], ak[3+i]);
        end
        u_eecwp_host_model.stop();
        repeat (12) @(posedge mclk);
    endtask : xfer

    task awr(input logic [13:0] a, input int exp_n);
        int n0;
        n0 = n_we;
        xfer(dev, {2'b00, a}, '{8'h5A, 8'h00, 8'h00}, 1);
        check("array write", 16'(n_we - n0), 16'(exp_n));
        if (exp_n == 1) check("array addr", 16'(last_addr), 16'(a));
        if (exp_n == 1) check("array data", 16'(last_data), 16'h005A);
    endtask : awr

    task t_levels();
        logic [13:0] b;
        int n0;
        for (int s = 0; s < 4; s++) begin
            n0 = n_we;
            xfer(dev, 16'h8000, '{8'h48 | 8'(s << 1), 8'h00, 8'h00}, 1);
            check("prot ack", 16'(ak), 16'h000F);
            check("cfg no array", 16'(n_we - n0), 16'h0000);
            check("prot view", 16'(prot_cfg_rd), 16'(8'h08 | 8'(s << 1)));
            b = 14'((3 - s) * 16'h1000);
            awr((s == 3) ? 14'h3FFF : b - 14'h0001, (s == 3) ? 0 : 1);
            awr(b, 0);
        end
        xfer(dev, 16'h8000, '{8'h46, 8'h00, 8'h00}, 1);
        check("prot view", 16'(prot_cfg_rd), 16'h0006);
        awr(14'h3FFF, 1);
        awr(14'h0000, 1);
    endtask : t_levels

    task t_addr();
        logic [7:0] dvs [4];
        dvs = '{DEV0, DEV5, 8'hBA, 8'hAB};
        xfer(DEV0, 16'h8000, '{8'h40, 8'h65, 8'h00}, 2);
        check("addr ack", 16'(ak), 16'h001F);
        check("addr view", 16'(addr_cfg_rd), 16'h0005);
        check("prot view", 16'(prot_cfg_rd), 16'h0000);
        for (int i = 0; i < 4; i++) begin
            xfer(dvs[i], 16'h0000, '{8'h00, 8'h00, 8'h00}, 0);
            check("dev ack", 16'(ak[0]), 16'(i == 1));
        end
        dev = DEV5;
    endtask : t_addr

    task t_refuse();
        logic [7:0] d0 [5];
        logic [7:0] d1 [5];
        int nb [5];
        d0 = '{8'h08, 8'h68, 8'h48, 8'h48, 8'h48};
        d1 = '{8'h00, 8'h00, 8'h27, 8'h47, 8'h42};
        nb = '{1, 1, 2, 2, 3};
        for (int i = 0; i < 5; i++) begin
            xfer(dev, 16'h8000, '{d0[i], d1[i], 8'h00}, nb[i]);
            check("refuse nack", 16'(ak[2+nb[i]]), 16'h0000);
            check("refuse prot", 16'(prot_cfg_rd), 16'h0000);
            check("refuse addr", 16'(addr_cfg_rd), 16'h0005);
        end
    endtask : t_refuse

    task t_lock();
        xfer(dev, 16'h8000, '{8'h61, 8'h00, 8'h00}, 1);
        check("lock view", 16'(prot_cfg_rd), 16'h0001);
        xfer(dev, 16'h8000, '{8'h69, 8'h60, 8'h00}, 2);
        check("locked nack", 16'(ak[3]), 16'h0000);
        check("locked prot", 16'(prot_cfg_rd), 16'h0001);
        check("locked addr", 16'(addr_cfg_rd), 16'h0005);
    endtask : t_lock

    task conclude();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        // A real falling edge, so the link-clock flops are reset as well
        resetn <= 1'b0;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        repeat (4) @(posedge mclk);
        check("reset prot", 16'(prot_cfg_rd), 16'h0000);
        check("reset addr", 16'(addr_cfg_rd), 16'h0000);
        t_levels();
        t_addr();
        t_refuse();
        t_lock();
        conclude();
    end
endmodule : tb

bind eecwp_core eecwp_checker #(.ADDR_W(ADDR_W)) u_eecwp_checker (.mclk,
    .resetn, .scl, .sda_i, .sda_o, .sda_oe, .arr_we, .arr_addr, .arr_data,
    .prot_cfg_rd, .addr_cfg_rd);
